// ===== pkg/timer_chan_cfg.svh
// Offsets, field positions, reset values and timing counts of the timer channel
`ifndef TIMER_CHAN_CFG_SVH
`define TIMER_CHAN_CFG_SVH
`define ADDR_CTRL 4'h0
`define ADDR_MODE 4'h1
`define ADDR_COUNTER 4'h2
`define ADDR_RELOAD 4'h3
`define ADDR_STATUS 4'h4
`define ADDR_MASK 4'h5
`define ADDR_EVENT 4'h6
`define CTRL_START 0
`define CTRL_CUTOFF 1
`define EVT_UP 0
`define EVT_ZPHASE 1
`define EVT_TRIGLO 2
`define EVT_TRIGHI 3
`define ST_IRQ 0
`define ST_OUT 1
`define MODE_RESET 2'h0
`define COUNT_RESET 16'hFFFF
`define ALL_ONES 16'hFFFF
`define ALL_ZEROS 16'h0000
`define TRIG_LEAD_NS 300
`define CLK_PERIOD_NS 10
`define TRIG_LEAD_CYC ((`TRIG_LEAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ===== pkg/timer_chan_pkg.sv
// Types shared by the timer channel
package timer_chan_pkg;
    typedef enum logic [1:0] {
        MODE_TIMER = 2'h0,
        MODE_EVENT = 2'h1,
        MODE_ONESHOT = 2'h2,
        MODE_PWM = 2'h3
    } mode_type;
endpackage

// ===== rtl/timer_a_multimode_counter.sv
// Multi-mode 16-bit timer channel with Avalon-MM register slave
// Notes on behaviour
// - Channel idle after reset until software sets the count start bit.
// - Counter readable while counting; timer-mode read at reload returns all ones.
// - Event-mode read at reload: all ones on underflow, zeros on overflow.
// - Counter written then read before counting returns the written value.
// - Cutoff enable set and shutdown low puts output pin in high impedance.
// - One-shot stop halts, reloads, drives output low; flag set one clock later.
// - One-shot output changes only on count source ticks and on a stop.
// - Selecting one-shot after reset or from timer/event mode sets the flag.
// - Trigger during one-shot reloads; count resumes after second trigger.
// - Selecting PWM after reset or from timer/event mode sets the flag.
// - Stop during PWM with output high drives low and sets the flag.
// - Stop during PWM with output low changes neither output nor flag.
//
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "timer_chan_cfg.svh"
module timer_a_multimode_counter #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Count source tick, external trigger and shutdown
    input wire logic countTick,
    input wire logic channelInputPin,
    input wire logic shutdownInput_n,
    // Output pin, enable low while driven
    input wire logic channelOutputPinIn,
    output logic channelOutputPin,
    output logic channelOutputPinOe_n,
    // Interrupt
    output logic irq
);
    import timer_chan_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic startQ, cutoffEnableQ;
    mode_type modeQ;
    logic modeWasSetQ;
    logic [WIDTH-1:0] counterQ, reloadQ;
    logic [3:0] eventCfgQ;
    logic [1:0] statusQ, maskQ;
    logic outQ;
    logic stopFlagPendQ;
    logic armedQ, trigSeenQ, reloadHitQ;
    logic readPendQ;
    logic [31:0] readdataQ;

    logic wrStrobe, tick, trigRise, trigPrevQ;
    logic underflow, overflow, reloadNow, stopEdge, modeFlagSet, hwIrqSet;
    logic [WIDTH-1:0] counterD;

    assign wrStrobe = write && !waitrequest;
    assign tick = countTick && startQ;
    assign trigRise = channelInputPin && !trigPrevQ;
    assign stopEdge = wrStrobe && address == `ADDR_CTRL && startQ && !writedata[`CTRL_START];

    ////////////////////////////////////////////////////////////////////////////
    // Reads take one wait cycle so readdata is registered
    // Writes never wait, so back-to-back writes cost one clock each
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            readPendQ <= 1'b0;
        end else begin
            readPendQ <= read && !readPendQ;
        end
    end
    assign waitrequest = read && !readPendQ;
    assign readdata = readdataQ;

    // Capture the counter view; a read that meets a reload sees the wrap value
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            readdataQ <= 32'h0000_0000;
        end else if (read && !readPendQ) begin
            case (address)
                `ADDR_CTRL: readdataQ <= {30'h0, cutoffEnableQ, startQ};
                `ADDR_MODE: readdataQ <= {30'h0, modeQ};
                `ADDR_COUNTER: begin
                    if (reloadNow && modeQ == MODE_EVENT && overflow) begin
                        readdataQ <= {16'h0, `ALL_ZEROS};
                    end else if (reloadNow) begin
                        readdataQ <= {16'h0, `ALL_ONES};
                    end else begin
                        readdataQ <= {16'h0, counterQ};
                    end
                end
                `ADDR_RELOAD: readdataQ <= {16'h0, reloadQ};
                `ADDR_STATUS: readdataQ <= {30'h0, outQ, statusQ[`ST_IRQ]};
                `ADDR_MASK: readdataQ <= {30'h0, maskQ};
                `ADDR_EVENT: readdataQ <= {28'h0, eventCfgQ};
                default: readdataQ <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control, mode and setup registers; mode and event setup writes are ignored while counting
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            startQ <= 1'b0;
            cutoffEnableQ <= 1'b0;
            modeQ <= MODE_TIMER;
            modeWasSetQ <= 1'b0;
            eventCfgQ <= 4'h0;
            maskQ <= 2'h0;
            reloadQ <= `COUNT_RESET;
        end else if (wrStrobe) begin
            case (address)
                `ADDR_CTRL: begin
                    startQ <= writedata[`CTRL_START];
                    cutoffEnableQ <= writedata[`CTRL_CUTOFF];
                end
                `ADDR_MODE: begin
                    if (!startQ) begin
                        modeQ <= mode_type'(writedata[1:0]);
                        modeWasSetQ <= 1'b1;
                    end
                end
                `ADDR_EVENT: begin
                    if (!startQ) begin
                        eventCfgQ <= writedata[3:0];
                    end
                end
                `ADDR_RELOAD: reloadQ <= writedata[WIDTH-1:0];
                `ADDR_COUNTER: reloadQ <= writedata[WIDTH-1:0];
                `ADDR_MASK: maskQ <= writedata[1:0];
                default: ;
            endcase
        end
    end

    // Mode switch into one-shot or PWM from reset, timer or event counter
    assign modeFlagSet = wrStrobe && address == `ADDR_MODE && !startQ
        && (writedata[1:0] == 2'(MODE_ONESHOT) || writedata[1:0] == 2'(MODE_PWM))
        && (!modeWasSetQ || modeQ == MODE_TIMER || modeQ == MODE_EVENT);

    ////////////////////////////////////////////////////////////////////////////
    // Counter next value
    // A counter write wins over stop and tick so software reads back its own value
    assign underflow = tick && counterQ == {WIDTH{1'b0}} && !(modeQ == MODE_EVENT && eventCfgQ[`EVT_UP]);
    assign overflow = tick && modeQ == MODE_EVENT && eventCfgQ[`EVT_UP] && counterQ == {WIDTH{1'b1}};
    assign reloadNow = (underflow || overflow) && (modeQ == MODE_TIMER || modeQ == MODE_EVENT);

    always_comb begin
        counterD = counterQ;
        if (wrStrobe && address == `ADDR_COUNTER) begin
            counterD = writedata[WIDTH-1:0];
        end else if (stopEdge && modeQ == MODE_ONESHOT) begin
            counterD = reloadQ;
        end else if (tick) begin
            case (modeQ)
                MODE_TIMER: counterD = underflow ? reloadQ : counterQ - 1'b1;
                MODE_EVENT: begin
                    if (reloadNow) begin
                        counterD = reloadQ;
                    end else if (eventCfgQ[`EVT_UP]) begin
                        counterD = counterQ + 1'b1;
                    end else begin
                        counterD = counterQ - 1'b1;
                    end
                end
                MODE_ONESHOT: begin
                    if (reloadHitQ) begin
                        counterD = reloadQ;
                    end else if (armedQ && counterQ != {WIDTH{1'b0}}) begin
                        counterD = counterQ - 1'b1;
                    end
                end
                MODE_PWM: counterD = (counterQ == {WIDTH{1'b0}}) ? reloadQ : counterQ - 1'b1;
                default: counterD = counterQ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            counterQ <= `COUNT_RESET;
        end else begin
            counterQ <= counterD;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // One-shot triggers: first arms, a trigger while counting reloads, next resumes
    // Two rises between ticks merge into one, hence triggers a tick apart
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            trigPrevQ <= 1'b0;
            armedQ <= 1'b0;
            trigSeenQ <= 1'b0;
            reloadHitQ <= 1'b0;
        end else begin
            trigPrevQ <= channelInputPin;
            if (!startQ || modeQ != MODE_ONESHOT) begin
                armedQ <= 1'b0;
                trigSeenQ <= 1'b0;
                reloadHitQ <= 1'b0;
            end else begin
                // Triggers are latched and acted on at the next count tick
                if (trigRise) begin
                    trigSeenQ <= 1'b1;
                end else if (tick) begin
                    trigSeenQ <= 1'b0;
                end
                if (tick && trigSeenQ) begin
                    if (armedQ && !reloadHitQ) begin
                        reloadHitQ <= 1'b1;
                    end else begin
                        reloadHitQ <= 1'b0;
                        armedQ <= 1'b1;
                    end
                end else if (tick && armedQ && counterQ == {WIDTH{1'b0}}) begin
                    armedQ <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output level; moves only on count ticks except for stop actions
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            outQ <= 1'b0;
        end else if (stopEdge && (modeQ == MODE_ONESHOT || modeQ == MODE_PWM)) begin
            outQ <= 1'b0;
        end else if (tick) begin
            case (modeQ)
                MODE_ONESHOT: outQ <= armedQ && !reloadHitQ && counterQ != {WIDTH{1'b0}};
                MODE_PWM: outQ <= counterQ != {WIDTH{1'b0}};
                default: outQ <= outQ;
            endcase
        end
    end

    // Forced cutoff releases the pin
    assign channelOutputPin = outQ;
    assign channelOutputPinOe_n = cutoffEnableQ && !shutdownInput_n;

    ////////////////////////////////////////////////////////////////////////////
    // One-shot stop flag lands one clock after the stop write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stopFlagPendQ <= 1'b0;
        end else begin
            stopFlagPendQ <= stopEdge && modeQ == MODE_ONESHOT;
        end
    end

    assign hwIrqSet = stopFlagPendQ || modeFlagSet || reloadNow
        || (stopEdge && modeQ == MODE_PWM && outQ)
        || (tick && modeQ == MODE_ONESHOT && armedQ && counterQ == {WIDTH{1'b0}})
        || (tick && modeQ == MODE_PWM && counterQ == {WIDTH{1'b0}});

    // Sticky status, write one to clear; a set in the same cycle wins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            statusQ <= 2'h0;
        end else begin
            statusQ[`ST_IRQ] <= hwIrqSet
                || (statusQ[`ST_IRQ] && !(wrStrobe && address == `ADDR_STATUS && writedata[`ST_IRQ]));
            statusQ[`ST_OUT] <= 1'b0;
        end
    end
    assign irq = |(statusQ & maskQ);

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    // Stop actions; the one-shot flag trails its stop write by one clock
    one_shot_stop_a: assert property (@(posedge clk) disable iff (!reset_n)
        (stopEdge && modeQ == MODE_ONESHOT) |=> !outQ && counterQ == $past(reloadQ) ##1 statusQ[`ST_IRQ])
        else $error("one-shot stop did not reload, drop output and flag");
    pwm_high_stop_a: assert property (@(posedge clk) disable iff (!reset_n)
        (stopEdge && modeQ == MODE_PWM && outQ) |=> !outQ && statusQ[`ST_IRQ])
        else $error("pwm stop with high output mishandled");
    pwm_low_stop_a: assert property (@(posedge clk) disable iff (!reset_n)
        (stopEdge && modeQ == MODE_PWM && !outQ && !hwIrqSet)
        |=> !outQ && statusQ[`ST_IRQ] == $past(statusQ[`ST_IRQ]))
        else $error("pwm stop with low output changed state");

    // Pin, output and mode checks
    cutoff_pin_a: assert property (@(posedge clk) disable iff (!reset_n)
        (cutoffEnableQ && !shutdownInput_n) |-> channelOutputPinOe_n)
        else $error("cutoff did not release output");
    out_on_tick_a: assert property (@(posedge clk) disable iff (!reset_n)
        !$past(tick) && !$past(stopEdge) |-> $stable(outQ))
        else $error("output moved without a count tick");
    one_shot_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        (tick && modeQ == MODE_ONESHOT && armedQ && counterQ == {WIDTH{1'b0}} && !stopEdge)
        |=> !outQ && statusQ[`ST_IRQ])
        else $error("one-shot end did not drop output and flag");
    mode_lock_a: assert property (@(posedge clk) disable iff (!reset_n)
        startQ && $past(startQ) |-> $stable(modeQ) && $stable(eventCfgQ))
        else $error("mode changed while counting");
    mode_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
        modeFlagSet |=> statusQ[`ST_IRQ])
        else $error("mode switch did not set flag");
    idle_reset_a: assert property (@(posedge clk) disable iff (!reset_n)
        !startQ && !(wrStrobe && address == `ADDR_COUNTER) && !stopEdge |=> $stable(counterQ))
        else $error("counter moved while idle");

    // Counter and read-back checks
    timer_reload_a: assert property (@(posedge clk) disable iff (!reset_n)
        (modeQ == MODE_TIMER && underflow && !wrStrobe) |=> counterQ == $past(reloadQ) && statusQ[`ST_IRQ])
        else $error("timer underflow did not reload and flag");
    timer_count_a: assert property (@(posedge clk) disable iff (!reset_n)
        (modeQ == MODE_TIMER && tick && !underflow && !wrStrobe) |=> counterQ == $past(counterQ) - 1'b1)
        else $error("timer did not decrement on tick");
    trigger_reload_a: assert property (@(posedge clk) disable iff (!reset_n)
        (tick && modeQ == MODE_ONESHOT && reloadHitQ && !wrStrobe) |=> counterQ == $past(reloadQ))
        else $error("trigger during one-shot did not reload");
    write_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wrStrobe && address == `ADDR_COUNTER && !startQ) |=> counterQ == $past(writedata[WIDTH-1:0]))
        else $error("written counter value lost");
    read_reload_a: assert property (@(posedge clk) disable iff (!reset_n)
        (read && !readPendQ && address == `ADDR_COUNTER && reloadNow && modeQ == MODE_TIMER)
        |=> readdata == 32'h0000_FFFF && !waitrequest)
        else $error("read at reload not all ones");
    event_over_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        (read && !readPendQ && address == `ADDR_COUNTER && reloadNow && modeQ == MODE_EVENT && overflow)
        |=> readdata == 32'h0000_0000)
        else $error("event overflow read not all zeros");
    event_under_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        (read && !readPendQ && address == `ADDR_COUNTER && reloadNow && modeQ == MODE_EVENT && underflow)
        |=> readdata == 32'h0000_FFFF)
        else $error("event underflow read not all ones");
    read_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        !(read && !readPendQ) |=> $stable(readdata))
        else $error("read data moved without a read");
endmodule
`default_nettype wire

// ===== verification/trigger_pin_model.sv
// Far-side model: trigger source, shutdown source and the output pin wire
`timescale 1ns/1ns
`default_nettype none
module trigger_pin_model (
    // Clock
    input wire logic clk,
    // Pin as driven by the channel
    input wire logic pinOut,
    input wire logic pinOe_n,
    // Signals toward the channel
    output logic trigger,
    output logic pinIn,
    output logic shutdown_n
);
    logic lastLevel;

    ////////////////////////////////////////////////////////////////
    // Idle levels at time zero
    initial begin
        trigger = 1'b0;
        shutdown_n = 1'b1;
        lastLevel = 1'b0;
    end

    // Released pin floats, so show the inverse of the last level, never a stale copy
    always @(posedge clk) begin
        if (!pinOe_n) begin
            lastLevel <= pinOut;
        end
    end
    assign pinIn = pinOe_n ? ~lastLevel : pinOut;

    ////////////////////////////////////////////////////////////////
    // One-clock trigger pulse after a gap, keeping pulses well apart
    task automatic fire(input int gap);
        repeat (gap) @(posedge clk);
        trigger <= 1'b1;
        @(posedge clk);
        trigger <= 1'b0;
    endtask

    // Shutdown level, changed just after an edge
    task automatic set_shutdown(input logic lvl);
        @(posedge clk);
        shutdown_n <= lvl;
    endtask
endmodule
`default_nettype wire

// ===== verification/timer_a_multimode_counter_tb.sv
// Self-checking bench for the multi-mode timer channel
`timescale 1ns/1ns
`default_nettype none
`include "timer_chan_cfg.svh"
module timer_a_multimode_counter_tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [31:0] readdata;
    logic waitrequest;
    logic countTick = 1'b0;
    logic trigger, pinIn, shutdown_n, pinOut, pinOe_n, irq;
    logic [31:0] rd;
    int errTotal = 0;
    int nCompared = 0;
    logic [1:0] fromMode [4] = '{2'h0, 2'h0, 2'h1, 2'h1};
    logic [1:0] toMode [4] = '{2'h2, 2'h3, 2'h2, 2'h3};

    ////////////////////////////////////////////////////////////////
    // Clock, design and far-side model
    always #5 clk = ~clk;

    timer_a_multimode_counter uut (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .countTick(countTick), .channelInputPin(trigger), .shutdownInput_n(shutdown_n),
        .channelOutputPinIn(pinIn), .channelOutputPin(pinOut), .channelOutputPinOe_n(pinOe_n), .irq(irq));

    trigger_pin_model partner (.clk(clk), .pinOut(pinOut), .pinOe_n(pinOe_n), .trigger(trigger),
        .pinIn(pinIn), .shutdown_n(shutdown_n));

    ////////////////////////////////////////////////////////////////
    // Bus cycles: request held until waitrequest is seen low at an edge
    task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        @(posedge clk);
        while (waitrequest) @(posedge clk);
        write <= 1'b0;
    endtask

    task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        address <= a;
        read <= 1'b1;
        @(posedge clk);
        while (waitrequest) @(posedge clk);
        d = readdata;
        read <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            errTotal++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        bus_read(a, rd);
        chk(rd, exp);
    endtask

    // Counter read whose first cycle meets a count tick
    task automatic rd_at_tick(input logic [31:0] exp);
        fork
            bus_read(`ADDR_COUNTER, rd);
            begin
                @(posedge clk);
                countTick <= 1'b1;
                @(posedge clk);
                countTick <= 1'b0;
            end
        join
        chk(rd, exp);
    endtask

    // One-clock count source pulses with idle cycles between them
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            countTick <= 1'b1;
            @(posedge clk);
            countTick <= 1'b0;
            @(posedge clk);
        end
    endtask

    task automatic report_and_stop();
        if (errTotal == 0 && nCompared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // Watchdog: ten thousand cycles, some forty times what the tests need
    initial begin
        #100000;
        errTotal++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        rd_chk(`ADDR_COUNTER, 32'(`COUNT_RESET));
        rd_chk(`ADDR_MODE, 32'(`MODE_RESET));
        rd_chk(4'h7, 32'h0000_0000);
        chk({31'h0, pinOe_n}, 32'h0000_0000);
        // Idle channel ignores ticks; written value reads back
        bus_write(`ADDR_COUNTER, 32'h0000_1234);
        tick(2);
        rd_chk(`ADDR_COUNTER, 32'h0000_1234);
        // Timer: decrement, then reload with flag on underflow
        bus_write(`ADDR_MASK, 32'h0000_0001);
        bus_write(`ADDR_COUNTER, 32'h0000_0003);
        bus_write(`ADDR_STATUS, 32'h0000_0001);
        bus_write(`ADDR_CTRL, 32'h0000_0001);
        tick(1);
        rd_chk(`ADDR_COUNTER, 32'h0000_0002);
        rd = 32'h0;
        for (int i = 0; i < 8 && rd[`ST_IRQ] !== 1'b1; i++) begin
            tick(1);
            bus_read(`ADDR_STATUS, rd);
        end
        chk({31'h0, rd[`ST_IRQ]}, 32'h0000_0001);
        rd_chk(`ADDR_COUNTER, 32'h0000_0003);
        chk({31'h0, irq}, 32'h0000_0001);
        bus_write(`ADDR_MASK, 32'h0000_0000);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0000_0000);
        bus_write(`ADDR_MASK, 32'h0000_0001);
        bus_write(`ADDR_STATUS, 32'h0000_0001);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0000_0000);
        // Mode and event setup refused while counting
        bus_write(`ADDR_MODE, 32'h0000_0002);
        rd_chk(`ADDR_MODE, 32'h0000_0000);
        bus_write(`ADDR_EVENT, 32'h0000_000F);
        rd_chk(`ADDR_EVENT, 32'h0000_0000);
        bus_write(`ADDR_CTRL, 32'h0000_0000);
        // Switching into one-shot or PWM from timer or event mode raises the flag
        for (int k = 0; k < 4; k++) begin
            bus_write(`ADDR_MODE, {30'h0, fromMode[k]});
            bus_write(`ADDR_STATUS, 32'h0000_0001);
            bus_write(`ADDR_MODE, {30'h0, toMode[k]});
            bus_read(`ADDR_STATUS, rd);
            chk({31'h0, rd[`ST_IRQ]}, 32'h0000_0001);
        end
        // One-shot: trigger, count to zero, then stop reloads and sets the flag
        bus_write(`ADDR_MODE, 32'h0000_0002);
        bus_write(`ADDR_STATUS, 32'h0000_0001);
        bus_write(`ADDR_COUNTER, 32'h0000_0005);
        bus_write(`ADDR_CTRL, 32'h0000_0001);
        partner.fire(2);
        tick(3);
        partner.fire(2);
        tick(2);
        rd_chk(`ADDR_COUNTER, 32'h0000_0005);
        partner.fire(2);
        tick(7);
        rd_chk(`ADDR_COUNTER, 32'h0000_0000);
        bus_write(`ADDR_STATUS, 32'h0000_0001);
        bus_write(`ADDR_CTRL, 32'h0000_0000);
        rd_chk(`ADDR_STATUS, 32'h0000_0001);
        rd_chk(`ADDR_COUNTER, 32'h0000_0005);
        // PWM: stop while high drives low and sets the flag
        bus_write(`ADDR_MODE, 32'h0000_0003);
        bus_write(`ADDR_COUNTER, 32'h0000_0004);
        bus_write(`ADDR_CTRL, 32'h0000_0001);
        tick(1);
        bus_write(`ADDR_STATUS, 32'h0000_0001);
        rd_chk(`ADDR_STATUS, 32'h0000_0002);
        bus_write(`ADDR_CTRL, 32'h0000_0000);
        rd_chk(`ADDR_STATUS, 32'h0000_0001);
        // PWM stop while low leaves output and flag alone
        bus_write(`ADDR_STATUS, 32'h0000_0001);
        bus_write(`ADDR_CTRL, 32'h0000_0001);
        bus_write(`ADDR_CTRL, 32'h0000_0000);
        rd_chk(`ADDR_STATUS, 32'h0000_0000);
        // Reads that meet a reload see the wrap value
        bus_write(`ADDR_MODE, 32'h0000_0001);
        bus_write(`ADDR_EVENT, 32'h0000_0001);
        bus_write(`ADDR_COUNTER, 32'h0000_FFFF);
        bus_write(`ADDR_CTRL, 32'h0000_0001);
        rd_at_tick(32'h0000_0000);
        bus_write(`ADDR_CTRL, 32'h0000_0000);
        bus_write(`ADDR_EVENT, 32'h0000_0000);
        bus_write(`ADDR_COUNTER, 32'h0000_0000);
        bus_write(`ADDR_CTRL, 32'h0000_0001);
        rd_at_tick(32'h0000_FFFF);
        bus_write(`ADDR_CTRL, 32'h0000_0000);
        bus_write(`ADDR_MODE, 32'h0000_0000);
        bus_write(`ADDR_COUNTER, 32'h0000_0000);
        bus_write(`ADDR_CTRL, 32'h0000_0001);
        rd_at_tick(32'h0000_FFFF);
        bus_write(`ADDR_CTRL, 32'h0000_0000);
        // Forced cutoff only with enable set and shutdown low
        partner.set_shutdown(1'b0);
        @(posedge clk);
        chk({31'h0, pinOe_n}, 32'h0000_0000);
        bus_write(`ADDR_CTRL, 32'h0000_0002);
        @(posedge clk);
        chk({31'h0, pinOe_n}, 32'h0000_0001);
        partner.set_shutdown(1'b1);
        @(posedge clk);
        chk({31'h0, pinOe_n}, 32'h0000_0000);
        report_and_stop();
    end
endmodule
`default_nettype wire
